/* hdl/bgc_pkg.sv */
// Package for the breathing-pattern and group configuration block
package bgc_pkg;

  // Register offsets on the internal register port
  localparam logic [7:0] BGC_OFS_PATTERN_CONFIG = 8'hA0;
  localparam logic [7:0] BGC_OFS_LOOP_COUNT_HIGH = 8'hA4;
  localparam logic [7:0] BGC_OFS_LOOP_COUNT_LOW = 8'hA5;
  localparam logic [7:0] BGC_OFS_BREATH_MAX = 8'hA6;
  localparam logic [7:0] BGC_OFS_BREATH_MIN = 8'hA7;
  localparam logic [7:0] BGC_OFS_SHARED_RED = 8'hA8;
  localparam logic [7:0] BGC_OFS_SHARED_GREEN = 8'hA9;
  localparam logic [7:0] BGC_OFS_SHARED_BLUE = 8'hAA;
  localparam logic [7:0] BGC_OFS_GROUP_CONFIG = 8'hAB;
  localparam logic [7:0] BGC_OFS_TRIPLE_ENABLE_LOW = 8'hAC;

  // Field positions
  localparam int BGC_BIT_PATTERN_CTRL_ENABLE = 0;
  localparam int BGC_BIT_SHARED_COLOUR_DISABLE = 4;
  localparam int BGC_LOOP_HIGH_MSB = 3;

  // Widths
  localparam int BGC_BYTE_W = 8;
  localparam int BGC_NIBBLE_W = 4;
  localparam int BGC_LOOP_W = 12;
  localparam int BGC_TRIPLES = 8;

  // Reset values
  localparam logic [7:0] BGC_RST_BYTE = 8'h00;
  localparam logic [3:0] BGC_RST_NIBBLE = 4'h0;
  localparam logic [0:0] BGC_RST_FLAG = 1'h0;
  localparam logic [11:0] BGC_LOOP_ENDLESS = 12'h000;
  localparam logic [7:0] BGC_UNMAPPED_READ = 8'h00;

  // Control mode of one LED triple, one-hot
  typedef enum logic [2:0] {
    BGC_MODE_INDIVIDUAL = 3'b001,
    BGC_MODE_GROUP = 3'b010,
    BGC_MODE_PATTERN = 3'b100
  } bgc_mode_type;

  // Shared colour mix values
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } bgc_colour_type;

  // Breathing settings handed to the pattern timers
  typedef struct packed {
    logic [11:0] loop_count;
    logic loop_endless;
    logic [7:0] max_level;
    logic [7:0] min_level;
  } bgc_breath_type;

  // Per-triple routing decision
  typedef struct packed {
    logic group_mode;
    logic pattern_mode;
    logic use_shared_colour;
  } bgc_route_type;

endpackage

/* hdl/bgc_reg_cell.sv */
// One read-write configuration register with write strobe
`timescale 1ns/1ps
module bgc_reg_cell #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic wr_en, // Write strobe for this register
  input wire logic [WIDTH-1:0] wdata, // Write data
  output logic [WIDTH-1:0] q // Stored value
);

  // Holds the value until software writes again
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= RESET_VALUE;
    end else if (wr_en) begin
      q <= wdata;
    end
  end

endmodule

/* hdl/bgc_triple_mode.sv */
// Control mode decision for one LED triple
`timescale 1ns/1ps
module bgc_triple_mode (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic triple_enable, // Enable bit for this triple
  input wire logic pattern_ctrl_enable, // Pattern controller enable
  input wire logic shared_colour_disable, // Use own colour registers
  output bgc_pkg::bgc_route_type route_r // Registered routing decision
);

  bgc_pkg::bgc_mode_type mode_nxt;
  bgc_pkg::bgc_route_type route_nxt;

  // Pick the controller that owns this triple
  always_comb begin
    if (!triple_enable) begin
      mode_nxt = bgc_pkg::BGC_MODE_INDIVIDUAL;
    end else if (pattern_ctrl_enable) begin
      mode_nxt = bgc_pkg::BGC_MODE_PATTERN;
    end else begin
      mode_nxt = bgc_pkg::BGC_MODE_GROUP;
    end
  end

  // Decode mode into routing bits
  always_comb begin
    route_nxt = '0;
    case (mode_nxt)
      bgc_pkg::BGC_MODE_GROUP: begin
        route_nxt.group_mode = 1'b1;
        route_nxt.use_shared_colour = ~shared_colour_disable;
      end
      bgc_pkg::BGC_MODE_PATTERN: begin
        route_nxt.pattern_mode = 1'b1;
        route_nxt.use_shared_colour = ~shared_colour_disable;
      end
      bgc_pkg::BGC_MODE_INDIVIDUAL: begin
        route_nxt = '0;
      end
      default: begin
        route_nxt = '0;
      end
    endcase
  end

  // Registered so the top output comes from a flop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      route_r <= '0;
    end else begin
      route_r <= route_nxt;
    end
  end

endmodule

/* hdl/bgc_top.sv */
// Breathing-pattern and group configuration registers with triple routing
`timescale 1ns/1ps
module bgc_top (
  input wire logic clk, // System clock, 10 MHz
  input wire logic sys_rst, // Async reset, active high
  input wire logic [7:0] reg_addr, // Register offset
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic reg_rd, // Read strobe, one cycle
  output logic [7:0] reg_rdata_r, // Read data, held until next read
  output logic reg_rvalid_r, // Read data valid pulse
  output bgc_pkg::bgc_breath_type breath_r, // Breathing settings
  output bgc_pkg::bgc_colour_type shared_colour_r, // Shared colour mix
  output logic pattern_ctrl_enable_r, // Pattern controller enable
  output logic shared_colour_disable_r, // Own colour registers in use
  output logic [23:0] led_group_mode_r, // Per LED: group mode
  output logic [23:0] led_pattern_mode_r, // Per LED: pattern mode
  output logic [23:0] led_shared_colour_r // Per LED: shared colour used
);

  // Write strobes per register
  logic wr_pattern_config;
  logic wr_loop_high;
  logic wr_loop_low;
  logic wr_max;
  logic wr_min;
  logic wr_red;
  logic wr_green;
  logic wr_blue;
  logic wr_group_config;
  logic wr_triple_low;

  // Stored register contents
  logic [0:0] pattern_ctrl_enable_q;
  logic [3:0] loop_count_high_q;
  logic [7:0] loop_count_low_reg_q;
  logic [7:0] breath_max_level_q;
  logic [7:0] breath_min_level_q;
  logic [7:0] shared_red_mix_q;
  logic [7:0] shared_green_mix_q;
  logic [7:0] shared_blue_mix_q;
  logic [0:0] shared_colour_disable_q;
  logic [7:0] triple_enable_q;

  // Combined count, read data and routing per triple
  logic [11:0] loop_count;
  logic [7:0] rdata_nxt;
  bgc_pkg::bgc_breath_type breath_nxt;
  bgc_pkg::bgc_route_type route [bgc_pkg::BGC_TRIPLES];

  // Address decode; unmapped writes are dropped
  // Offsets outside the map raise no strobe at all
  always_comb begin
    wr_pattern_config = reg_wr && (reg_addr == bgc_pkg::BGC_OFS_PATTERN_CONFIG);
    wr_loop_high = reg_wr && (reg_addr == bgc_pkg::BGC_OFS_LOOP_COUNT_HIGH);
    wr_loop_low = reg_wr && (reg_addr == bgc_pkg::BGC_OFS_LOOP_COUNT_LOW);
    wr_max = reg_wr && (reg_addr == bgc_pkg::BGC_OFS_BREATH_MAX);
    wr_min = reg_wr && (reg_addr == bgc_pkg::BGC_OFS_BREATH_MIN);
    wr_red = reg_wr && (reg_addr == bgc_pkg::BGC_OFS_SHARED_RED);
    wr_green = reg_wr && (reg_addr == bgc_pkg::BGC_OFS_SHARED_GREEN);
    wr_blue = reg_wr && (reg_addr == bgc_pkg::BGC_OFS_SHARED_BLUE);
    wr_group_config = reg_wr && (reg_addr == bgc_pkg::BGC_OFS_GROUP_CONFIG);
    wr_triple_low = reg_wr && (reg_addr == bgc_pkg::BGC_OFS_TRIPLE_ENABLE_LOW);
  end

  // Pattern controller enable, the only writable bit here
  // Other bits of this offset belong to the pattern run control
  bgc_reg_cell #(.WIDTH(1), .RESET_VALUE(bgc_pkg::BGC_RST_FLAG)) u_pattern_enable (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(wr_pattern_config),
    .wdata(reg_wdata[bgc_pkg::BGC_BIT_PATTERN_CTRL_ENABLE]),
    .q(pattern_ctrl_enable_q)
  );

  // Upper nibble of the loop count
  // Upper half of that offset holds start and end points, kept elsewhere
  bgc_reg_cell #(.WIDTH(4), .RESET_VALUE(bgc_pkg::BGC_RST_NIBBLE)) u_loop_high (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(wr_loop_high),
    .wdata(reg_wdata[bgc_pkg::BGC_LOOP_HIGH_MSB:0]),
    .q(loop_count_high_q)
  );

  // Lower byte of the loop count
  bgc_reg_cell #(.WIDTH(8), .RESET_VALUE(bgc_pkg::BGC_RST_BYTE)) u_loop_low (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(wr_loop_low),
    .wdata(reg_wdata),
    .q(loop_count_low_reg_q)
  );

  // Breathing ceiling
  bgc_reg_cell #(.WIDTH(8), .RESET_VALUE(bgc_pkg::BGC_RST_BYTE)) u_max (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(wr_max),
    .wdata(reg_wdata),
    .q(breath_max_level_q)
  );

  // Breathing floor
  bgc_reg_cell #(.WIDTH(8), .RESET_VALUE(bgc_pkg::BGC_RST_BYTE)) u_min (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(wr_min),
    .wdata(reg_wdata),
    .q(breath_min_level_q)
  );

  // Shared red mix
  bgc_reg_cell #(.WIDTH(8), .RESET_VALUE(bgc_pkg::BGC_RST_BYTE)) u_red (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(wr_red),
    .wdata(reg_wdata),
    .q(shared_red_mix_q)
  );

  // Shared green mix
  bgc_reg_cell #(.WIDTH(8), .RESET_VALUE(bgc_pkg::BGC_RST_BYTE)) u_green (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(wr_green),
    .wdata(reg_wdata),
    .q(shared_green_mix_q)
  );

  // Shared blue mix
  bgc_reg_cell #(.WIDTH(8), .RESET_VALUE(bgc_pkg::BGC_RST_BYTE)) u_blue (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(wr_blue),
    .wdata(reg_wdata),
    .q(shared_blue_mix_q)
  );

  // Shared colour disable; enables of LED25-36 live elsewhere
  bgc_reg_cell #(.WIDTH(1), .RESET_VALUE(bgc_pkg::BGC_RST_FLAG)) u_colour_dis (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(wr_group_config),
    .wdata(reg_wdata[bgc_pkg::BGC_BIT_SHARED_COLOUR_DISABLE]),
    .q(shared_colour_disable_q)
  );

  // Triple enables for LED1-24
  // Bit n owns LEDs 3n+1 to 3n+3
  bgc_reg_cell #(.WIDTH(8), .RESET_VALUE(bgc_pkg::BGC_RST_BYTE)) u_triple_low (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(wr_triple_low),
    .wdata(reg_wdata),
    .q(triple_enable_q)
  );

  // Full count and endless detection
  always_comb begin
    loop_count = {loop_count_high_q, loop_count_low_reg_q};
    breath_nxt.loop_count = loop_count;
    breath_nxt.loop_endless = (loop_count == bgc_pkg::BGC_LOOP_ENDLESS);
    breath_nxt.max_level = breath_max_level_q;
    breath_nxt.min_level = breath_min_level_q;
  end

  // Breathing settings, one flop stage
  // A cleared count means endless, so reset shows the endless flag set
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      breath_r.loop_count <= bgc_pkg::BGC_LOOP_ENDLESS;
      breath_r.loop_endless <= 1'b1;
      breath_r.max_level <= bgc_pkg::BGC_RST_BYTE;
      breath_r.min_level <= bgc_pkg::BGC_RST_BYTE;
    end else begin
      breath_r <= breath_nxt;
    end
  end

  // Shared colour mix, one flop stage
  // Stage costs a cycle but keeps outputs glitch free
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shared_colour_r <= '0;
    end else begin
      shared_colour_r <= {shared_red_mix_q, shared_green_mix_q, shared_blue_mix_q};
    end
  end

  // Pattern controller enable seen by the timers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pattern_ctrl_enable_r <= 1'b0;
    end else begin
      pattern_ctrl_enable_r <= pattern_ctrl_enable_q[0];
    end
  end

  // Shared colour disable seen by the colour path
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shared_colour_disable_r <= 1'b0;
    end else begin
      shared_colour_disable_r <= shared_colour_disable_q[0];
    end
  end

  // One mode decision per triple, fanned to its three LEDs
  // Route flops sit in each triple cell, so these vectors
  // come straight from flops without a second stage
  for (genvar t = 0; t < bgc_pkg::BGC_TRIPLES; t++) begin : g_triple
    bgc_triple_mode u_mode (
      .clk(clk),
      .sys_rst(sys_rst),
      .triple_enable(triple_enable_q[t]),
      .pattern_ctrl_enable(pattern_ctrl_enable_q[0]),
      .shared_colour_disable(shared_colour_disable_q[0]),
      .route_r(route[t])
    );
    always_comb begin
      led_group_mode_r[3*t +: 3] = {3{route[t].group_mode}};
      led_pattern_mode_r[3*t +: 3] = {3{route[t].pattern_mode}};
      led_shared_colour_r[3*t +: 3] = {3{route[t].use_shared_colour}};
    end
  end

  // Read mux; reserved bits and unmapped offsets read zero
  // A read and a write in one cycle return the old contents
  always_comb begin
    case (reg_addr)
      bgc_pkg::BGC_OFS_PATTERN_CONFIG: begin
        rdata_nxt = '0;
        rdata_nxt[bgc_pkg::BGC_BIT_PATTERN_CTRL_ENABLE] = pattern_ctrl_enable_q[0];
      end
      bgc_pkg::BGC_OFS_LOOP_COUNT_HIGH: begin
        rdata_nxt = {bgc_pkg::BGC_RST_NIBBLE, loop_count_high_q};
      end
      bgc_pkg::BGC_OFS_LOOP_COUNT_LOW: begin
        rdata_nxt = loop_count_low_reg_q;
      end
      bgc_pkg::BGC_OFS_BREATH_MAX: begin
        rdata_nxt = breath_max_level_q;
      end
      bgc_pkg::BGC_OFS_BREATH_MIN: begin
        rdata_nxt = breath_min_level_q;
      end
      bgc_pkg::BGC_OFS_SHARED_RED: begin
        rdata_nxt = shared_red_mix_q;
      end
      bgc_pkg::BGC_OFS_SHARED_GREEN: begin
        rdata_nxt = shared_green_mix_q;
      end
      bgc_pkg::BGC_OFS_SHARED_BLUE: begin
        rdata_nxt = shared_blue_mix_q;
      end
      bgc_pkg::BGC_OFS_GROUP_CONFIG: begin
        rdata_nxt = '0;
        rdata_nxt[bgc_pkg::BGC_BIT_SHARED_COLOUR_DISABLE] = shared_colour_disable_q[0];
      end
      bgc_pkg::BGC_OFS_TRIPLE_ENABLE_LOW: begin
        rdata_nxt = triple_enable_q;
      end
      default: begin
        rdata_nxt = bgc_pkg::BGC_UNMAPPED_READ;
      end
    endcase
  end

  // Read valid, one pulse per read strobe
  // Data then stays in reg_rdata_r until the next read strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_rd;
    end
  end

  // Read data captured on the strobe and held
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_r <= bgc_pkg::BGC_RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata_r <= rdata_nxt;
    end
  end

endmodule

/* dv/bgc_props.sv */
// Port assertions for the breathing and group configuration block
`timescale 1ns/1ps
module bgc_props (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Async reset
  input wire logic [7:0] reg_addr, // Register offset
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata_r, // Read data
  input wire logic reg_rvalid_r, // Read valid
  input wire bgc_pkg::bgc_breath_type breath_r, // Breathing settings
  input wire bgc_pkg::bgc_colour_type shared_colour_r, // Shared colour
  input wire logic pattern_ctrl_enable_r, // Pattern enable
  input wire logic shared_colour_disable_r, // Own colour in use
  input wire logic [23:0] led_group_mode_r, // Group mode
  input wire logic [23:0] led_pattern_mode_r, // Pattern mode
  input wire logic [23:0] led_shared_colour_r // Shared colour used
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Writes show on the outputs two edges after the strobe
  a_high_nibble: assert property (reg_wr && reg_addr == 8'hA4 |-> ##2
    {4'h0, breath_r.loop_count[11:8]} == ($past(reg_wdata, 2) & 8'h0F))
    else $error("loop count high nibble wrong");
  a_low_byte: assert property (reg_wr && reg_addr == 8'hA5 |-> ##2
    breath_r.loop_count[7:0] == $past(reg_wdata, 2)) else $error("loop count low byte wrong");
  a_max_level: assert property (reg_wr && reg_addr == 8'hA6 |-> ##2
    breath_r.max_level == $past(reg_wdata, 2)) else $error("max level wrong");
  a_min_level: assert property (reg_wr && reg_addr == 8'hA7 |-> ##2
    breath_r.min_level == $past(reg_wdata, 2)) else $error("min level wrong");
  a_red_mix: assert property (reg_wr && reg_addr == 8'hA8 |-> ##2
    shared_colour_r.red == $past(reg_wdata, 2)) else $error("red mix wrong");
  a_enable_flag: assert property (reg_wr && reg_addr == 8'hA0 |-> ##2
    {7'h0, pattern_ctrl_enable_r} == ($past(reg_wdata, 2) & 8'h01))
    else $error("pattern enable flag wrong");
  a_read_valid: assert property (reg_rd |=> reg_rvalid_r ##1 !reg_rvalid_r)
    else $error("read valid not a one cycle pulse");
  a_endless_zero: assert property (breath_r.loop_endless == (breath_r.loop_count == 12'h000))
    else $error("endless flag disagrees with loop count");
  a_group_mode: assert property (|led_group_mode_r |-> !pattern_ctrl_enable_r)
    else $error("group mode while pattern enabled");
  a_pattern_mode: assert property (|led_pattern_mode_r |-> pattern_ctrl_enable_r)
    else $error("pattern mode while pattern disabled");
  a_shared_colour: assert property (led_shared_colour_r ==
    ((led_group_mode_r | led_pattern_mode_r) & {24{!shared_colour_disable_r}}))
    else $error("shared colour selection wrong");
endmodule

bind bgc_top bgc_props u_props (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
  .reg_rvalid_r(reg_rvalid_r), .breath_r(breath_r), .shared_colour_r(shared_colour_r),
  .pattern_ctrl_enable_r(pattern_ctrl_enable_r),
  .shared_colour_disable_r(shared_colour_disable_r), .led_group_mode_r(led_group_mode_r),
  .led_pattern_mode_r(led_pattern_mode_r), .led_shared_colour_r(led_shared_colour_r));

/* dv/bgc_host_model.sv */
// Host model driving the register strobe port
`timescale 1ns/1ps
module bgc_host_model (
  input wire logic clk, // System clock
  output logic [7:0] reg_addr, // Register offset
  output logic [7:0] reg_wdata, // Write data
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata_r, // Read data
  input wire logic reg_rvalid_r // Read valid
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Released lines go inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // Answer stands just after the same edge that takes the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    // Valid stands for one cycle only, so take it before the next edge
    d = reg_rdata_r;
    v = reg_rvalid_r;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask

  // Stop an endless pattern: leave pattern control first, then release triples
  task automatic stop_endless();
    wr(8'hA0, 8'h00);
    wr(8'hAC, 8'h00);
  endtask
endmodule

/* dv/testbench.sv */
// Self-checking testbench for the breathing and group configuration block
`timescale 1ns/1ps
module testbench;
  logic clk;
  logic sys_rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata_r;
  logic reg_rvalid_r;
  bgc_pkg::bgc_breath_type breath_r;
  bgc_pkg::bgc_colour_type shared_colour_r;
  logic pattern_ctrl_enable_r;
  logic shared_colour_disable_r;
  logic [23:0] led_group_mode_r;
  logic [23:0] led_pattern_mode_r;
  logic [23:0] led_shared_colour_r;
  logic [7:0] rd_v;
  logic rd_ok;
  int n_fail;
  int n_tests;

  bgc_top DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r),
    .breath_r(breath_r), .shared_colour_r(shared_colour_r),
    .pattern_ctrl_enable_r(pattern_ctrl_enable_r),
    .shared_colour_disable_r(shared_colour_disable_r), .led_group_mode_r(led_group_mode_r),
    .led_pattern_mode_r(led_pattern_mode_r), .led_shared_colour_r(led_shared_colour_r));

  bgc_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r));

  task automatic summarize();
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Bits each offset really holds; unmapped places read zero
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'hA0: msk = 8'h01;
      8'hA4: msk = 8'h0F;
      8'hAB: msk = 8'h10;
      8'hA1, 8'hA2, 8'hA3: msk = 8'h00;
      default: msk = 8'hFF;
    endcase
  endfunction

  // Outputs trail the register by one flop stage
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic t_reset();
    for (int a = 8'hA0; a <= 8'hAC; a++) begin
      host.rd(8'(a), rd_v, rd_ok);
      chk("reset read", {15'h0, rd_ok, rd_v}, 24'h100);
    end
    chk("reset endless", {23'h0, breath_r.loop_endless}, 24'h1);
  endtask

  task automatic t_rw();
    for (int a = 8'hA0; a <= 8'hAC; a++) host.wr(8'(a), 8'(a) ^ 8'h3C);
    for (int a = 8'hA0; a <= 8'hAC; a++) begin
      host.rd(8'(a), rd_v, rd_ok);
      chk("readback", {16'h0, rd_v}, {16'h0, (8'(a) ^ 8'h3C) & msk(8'(a))});
    end
    host.rd(8'h50, rd_v, rd_ok);
    chk("unmapped", {15'h0, rd_ok, rd_v}, 24'h100);
    chk("loop count", {12'h0, breath_r.loop_count}, 24'h899);
    chk("levels", {8'h0, breath_r.max_level, breath_r.min_level}, 24'h9A9B);
    chk("colour", shared_colour_r, 24'h949596);
    chk("flags", {22'h0, pattern_ctrl_enable_r, shared_colour_disable_r}, 24'h1);
    chk("group", led_group_mode_r, 24'hE07000);
  endtask

  task automatic t_endless();
    host.wr(8'hA4, 8'h00);
    host.wr(8'hA5, 8'h01);
    settle();
    chk("endless low", {23'h0, breath_r.loop_endless}, 24'h0);
    host.wr(8'hA5, 8'h00);
    settle();
    chk("endless zero", {23'h0, breath_r.loop_endless}, 24'h1);
    host.wr(8'hA4, 8'h08);
    settle();
    chk("endless high", {23'h0, breath_r.loop_endless}, 24'h0);
    host.stop_endless();
    settle();
    chk("stopped", led_pattern_mode_r | led_group_mode_r, 24'h0);
  endtask

  // Reset in mid-run brings the breathing levels and endless flag back to their defaults
  task automatic t_rst_mid();
    host.wr(8'hA6, 8'h5A);
    @(posedge clk);
    #1;
    sys_rst = 1'b1;
    @(posedge clk);
    #1;
    chk("mid reset levels", {8'h0, breath_r.max_level, breath_r.min_level}, 24'h0);
    chk("mid reset endless", {23'h0, breath_r.loop_endless}, 24'h1);
    sys_rst = 1'b0;
    host.rd(8'hA6, rd_v, rd_ok);
    chk("mid reset read", {15'h0, rd_ok, rd_v}, 24'h100);
  endtask

  task automatic t_route();
    logic [23:0] m;
    for (int p = 0; p < 2; p++)
      for (int d = 0; d < 2; d++)
        for (int n = 0; n < 8; n++) begin
          m = 24'h7 << (3 * n);
          host.wr(8'hA0, 8'(p));
          host.wr(8'hAB, 8'(d << 4));
          host.wr(8'hAC, 8'(1 << n));
          settle();
          chk("group mode", led_group_mode_r, p ? 24'h0 : m);
          chk("pattern mode", led_pattern_mode_r, p ? m : 24'h0);
          chk("shared", led_shared_colour_r, d ? 24'h0 : m);
        end
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Whole run is a few hundred cycles; this limit only catches a hang
  initial begin
    #(5000 * 100);
    n_fail++;
    summarize();
  end

  initial begin
    n_fail = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_reset();
    t_rw();
    t_endless();
    t_rst_mid();
    t_route();
    summarize();
  end
endmodule
